// ### src/mailbox_pkg.sv
/*
  Shared constants and carriers of the host mailbox port.
  Assumes a single core clock; host pins are asynchronous to it.
*/
package mailbox_pkg;
  // --------------------------------------------------------------
  // Register map and fields
  // --------------------------------------------------------------
  localparam int NUM_DATA = 6;
  localparam logic [2:0] ADDR_STAT_LO = 3'h6;
  localparam logic [2:0] ADDR_STAT_HI = 3'h7;
  localparam int SRST_BIT = 7;
  localparam logic [7:0] UPPER_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // --------------------------------------------------------------
  // Timing and interrupt table
  // --------------------------------------------------------------
  localparam int SRST_CYCLES = 5;
  localparam int NUM_SRC = 11;
  localparam logic [15:0] VEC_RESET = 16'h0000;
  localparam logic [15:0] VEC_TAB [0:10] = '{16'h002C, 16'h0004, 16'h0008,
    16'h000C, 16'h0010, 16'h0014, 16'h0018, 16'h001C, 16'h0020, 16'h0024,
    16'h0028};
  localparam int SRC_HIP_WR = 2;
  localparam int SRC_HIP_RD = 3;

  // Host pins after synchronisation
  typedef struct packed {
    logic sel_n;
    logic rd_or_dir;
    logic wr_or_strobe;
    logic addr2_or_latch;
    logic [1:0] addr_low;
    logic [7:0] bus;
  } host_pins_t;

  typedef struct packed {
    logic strobe_style;
    logic bus_mux;
    logic boot_source;
    logic memory_map;
  } straps_t;
endpackage

// ### src/host_mailbox_port.sv
/*
  Host mailbox port: host pin decoder, mailbox registers, soft reset,
  boot byte FIFO and the interrupt priority logic.
  Assumes straps are steady after reset; core is on mclk.
*/
module boot_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // Elaboration check: pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be power of 2");
  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  assign in_ready = (wp_r - rp_r) != (AW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign out_data = mem[rp_r[AW-1:0]];
  // Pointers carry a wrap bit so full and empty stay distinct
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      if (in_valid && in_ready) wp_r <= wp_r + 1'b1;
      if (out_valid && out_ready) rp_r <= rp_r + 1'b1;
    end
  always_ff @(posedge mclk)
    if (in_valid && in_ready) mem[wp_r[AW-1:0]] <= in_data;
endmodule // boot_fifo

module irq_prio (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [2:0] ext_irq_n,
  input wire logic [2:0] irq_control_reg,
  input wire logic [10:0] src_pulse,
  input wire logic [9:0] global_irq_mask,
  input wire logic [10:0] force_bits,
  input wire logic [10:0] clear_bits,
  input wire logic irq_force_clear_we,
  input wire logic ints_enable,
  input wire logic ints_disable,
  input wire logic irq_ack,
  input wire logic soft_rst,
  output logic irq_valid,
  output logic [15:0] irq_vector
);
  logic [2:0] x1_r, x2_r, x3_r, xs_r;
  logic [10:0] pend_r;
  logic int_en_r;
  logic [10:0] req;
  logic [10:0] edge_set;
  logic [3:0] sel_idx;
  logic found;
  // Pin sync; a level counts only once stages two and three agree
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      x1_r <= 3'h7;
      x2_r <= 3'h7;
      x3_r <= 3'h7;
      xs_r <= 3'h7;
    end
    else
    begin
      x1_r <= ext_irq_n;
      x2_r <= x1_r;
      x3_r <= x2_r;
      xs_r <= (x2_r == x3_r) ? x3_r : xs_r;
    end
  // Pins: 0 dedicated (slot 1), 1 ext_irq_b (slot 8), 2 ext_irq_a (slot 9)
  always_comb
  begin
    edge_set = src_pulse;
    // Only edge pins latch, so a pin in level mode never leaves a stale edge pending
    edge_set[1] = src_pulse[1] | (irq_control_reg[0] & xs_r[0] & ~x3_r[0]
      & (x2_r[0] == x3_r[0]));
    edge_set[8] = src_pulse[8] | (irq_control_reg[1] & xs_r[1] & ~x3_r[1]
      & (x2_r[1] == x3_r[1]));
    edge_set[9] = src_pulse[9] | (irq_control_reg[2] & xs_r[2] & ~x3_r[2]
      & (x2_r[2] == x3_r[2]));
  end
  // Set and force win over acknowledge and clear
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst) pend_r <= '0;
    else
      pend_r <= (pend_r & ~(irq_force_clear_we ? clear_bits : 11'h000)
        & ~((irq_ack && found) ? (11'h001 << sel_idx) : 11'h000))
        | edge_set | (irq_force_clear_we ? force_bits : 11'h000);
  // Servicing enabled out of reset
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst) int_en_r <= 1'b1;
    else if (ints_disable) int_en_r <= 1'b0;
    else if (ints_enable) int_en_r <= 1'b1;
  // Level pins bypass the latch; powerdown bypasses the mask
  always_comb
  begin
    req = pend_r;
    req[1] = irq_control_reg[0] ? pend_r[1] : ~xs_r[0];
    req[8] = irq_control_reg[1] ? pend_r[8] : ~xs_r[1];
    req[9] = irq_control_reg[2] ? pend_r[9] : ~xs_r[2];
    req = req & {global_irq_mask, 1'b1};
    found = 1'b0;
    sel_idx = 4'h0;
    for (int i = 0; i < mailbox_pkg::NUM_SRC; i++)
      if (req[i] && !found)
      begin
        found = 1'b1;
        sel_idx = 4'(i);
      end
  end
  assign irq_valid = soft_rst | (int_en_r & found);
  assign irq_vector = soft_rst ? mailbox_pkg::VEC_RESET
    : mailbox_pkg::VEC_TAB[sel_idx];

  property p_global_off;
    @(posedge mclk) disable iff (sys_rst) !int_en_r && !soft_rst |-> !irq_valid;
  endproperty
  a_global_off: assert property (p_global_off) else $error("irq while disabled");
  property p_wr_over_rd;
    @(posedge mclk) disable iff (sys_rst)
      int_en_r && !soft_rst && req[mailbox_pkg::SRC_HIP_WR] && !req[0] && !req[1]
      |-> irq_vector == 16'h0008;
  endproperty
  a_wr_over_rd: assert property (p_wr_over_rd) else $error("write vector");
endmodule // irq_prio

module host_mailbox_port (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic host_sel_n,
  input wire logic host_read_or_dir,
  input wire logic host_write_or_strobe,
  input wire logic host_addr2_or_latch,
  input wire logic [1:0] host_addr_low,
  input wire logic [7:0] host_byte_bus_in,
  output logic [7:0] host_byte_bus_out,
  output logic host_byte_bus_oe,
  output logic host_ack_out,
  input wire logic strobe_style_strap,
  input wire logic bus_mux_strap,
  input wire logic boot_source_strap,
  input wire logic memory_map_pin,
  input wire logic [2:0] core_addr,
  input wire logic core_we,
  input wire logic core_re,
  input wire logic [15:0] core_wdata,
  output logic [15:0] core_rdata,
  input wire logic [11:0] per_register_irq_mask,
  output logic boot_valid,
  input wire logic boot_ready,
  output logic [7:0] boot_byte,
  output logic soft_rst,
  input wire logic [2:0] ext_irq_n,
  input wire logic [2:0] irq_control_reg,
  input wire logic [8:0] other_irq_pulse,
  input wire logic [9:0] global_irq_mask,
  input wire logic [10:0] force_bits,
  input wire logic [10:0] clear_bits,
  input wire logic irq_force_clear_we,
  input wire logic ints_enable,
  input wire logic ints_disable,
  input wire logic irq_ack,
  output logic irq_valid,
  output logic [15:0] irq_vector
);
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_RD = 3'b010, ST_WR = 3'b100} hst_t;
  mailbox_pkg::host_pins_t p1_r, p2_r, p3_r, ps_r;
  mailbox_pkg::straps_t strap_r;
  logic strap_done_r;
  hst_t st_r;
  logic [15:0] data_r [0:5];
  logic [5:0] wflag_r, rflag_r, wr_pulse_r, rd_pulse_r;
  logic [2:0] addr_lat_r, acc_addr_r, haddr;
  logic wr_done_r, srst_bit_r, srst_go;
  logic [2:0] srst_cnt_r;
  logic rd_act, wr_act, sel, boot_mode, fifo_ready, push;
  logic [7:0] host_view;

  // --------------------------------------------------------------
  // Host pin synchronisers
  // --------------------------------------------------------------
  // Three stages; a change counts once stages two and three agree
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      p1_r <= '1;
      p2_r <= '1;
      p3_r <= '1;
      ps_r <= '1;
    end
    else
    begin
      p1_r <= {host_sel_n, host_read_or_dir, host_write_or_strobe,
        host_addr2_or_latch, host_addr_low, host_byte_bus_in};
      p2_r <= p1_r;
      p3_r <= p2_r;
      ps_r <= (p2_r == p3_r) ? p3_r : ps_r;
    end
  // Straps caught once after reset release, never under reset
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      strap_r <= '0;
      strap_done_r <= 1'b0;
    end
    else if (!strap_done_r)
    begin
      strap_r <= {strobe_style_strap, bus_mux_strap, boot_source_strap, memory_map_pin};
      strap_done_r <= 1'b1;
    end

  // Strobe decode by style; all host strobes are active low
  assign sel = ~ps_r.sel_n & strap_done_r;
  assign rd_act = strap_r.strobe_style ? (~ps_r.wr_or_strobe & ps_r.rd_or_dir)
    : ~ps_r.rd_or_dir;
  assign wr_act = strap_r.strobe_style ? (~ps_r.wr_or_strobe & ~ps_r.rd_or_dir)
    : ~ps_r.wr_or_strobe;
  assign haddr = strap_r.bus_mux ? addr_lat_r
    : {ps_r.addr2_or_latch, ps_r.addr_low};
  assign boot_mode = ~strap_r.memory_map & strap_r.boot_source;
  // Multiplexed bus: address follows the bus while the latch enable is high
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst) addr_lat_r <= 3'h0;
    else if (ps_r.addr2_or_latch) addr_lat_r <= ps_r.bus[2:0];

  // --------------------------------------------------------------
  // Host access sequencer
  // --------------------------------------------------------------
  // A full boot FIFO withholds the write ack, stalling the host
  assign push = (st_r == ST_WR) && !wr_done_r && boot_mode;
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      st_r <= ST_IDLE;
      acc_addr_r <= 3'h0;
      wr_done_r <= 1'b0;
    end
    else
      unique case (st_r)
        ST_IDLE:
        begin
          acc_addr_r <= haddr;
          wr_done_r <= 1'b0;
          if (sel && rd_act) st_r <= ST_RD;
          else if (sel && wr_act) st_r <= ST_WR;
        end
        ST_RD:
          if (!(sel && rd_act)) st_r <= ST_IDLE;
        ST_WR:
        begin
          if (!boot_mode || fifo_ready) wr_done_r <= 1'b1;
          if (wr_done_r && !(sel && wr_act)) st_r <= ST_IDLE;
        end
      endcase
  assign host_ack_out = (st_r == ST_RD) || (st_r == ST_WR && wr_done_r);
  assign host_byte_bus_oe = (st_r == ST_RD);
  // Read byte is frozen at access start, valid on the edge that raises ack
  always_comb
    if (haddr == mailbox_pkg::ADDR_STAT_LO) host_view = {2'b00, wflag_r};
    else if (haddr == mailbox_pkg::ADDR_STAT_HI) host_view = {srst_bit_r, 1'b0, rflag_r};
    else host_view = data_r[haddr][7:0];
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst) host_byte_bus_out <= 8'h00;
    else if (st_r == ST_IDLE && sel && rd_act) host_byte_bus_out <= host_view;

  // One-cycle event pulses per data register
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      wr_pulse_r <= '0;
      rd_pulse_r <= '0;
    end
    else
    begin
      wr_pulse_r <= '0;
      rd_pulse_r <= '0;
      if (st_r == ST_WR && !wr_done_r && !boot_mode && acc_addr_r < 3'(mailbox_pkg::NUM_DATA))
        wr_pulse_r[acc_addr_r] <= 1'b1;
      if (st_r == ST_RD && !(sel && rd_act) && acc_addr_r < 3'(mailbox_pkg::NUM_DATA))
        rd_pulse_r[acc_addr_r] <= 1'b1;
    end

  // --------------------------------------------------------------
  // Mailbox registers and status
  // --------------------------------------------------------------
  // Data words: host loads byte with upper zeros, core loads whole word
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
      for (int i = 0; i < mailbox_pkg::NUM_DATA; i++) data_r[i] <= mailbox_pkg::WORD_ZERO;
    else if (st_r == ST_WR && !wr_done_r && !boot_mode && acc_addr_r < 3'(mailbox_pkg::NUM_DATA))
      data_r[acc_addr_r] <= {mailbox_pkg::UPPER_ZERO, ps_r.bus};
    else if (core_we && core_addr < 3'(mailbox_pkg::NUM_DATA))
      data_r[core_addr] <= core_wdata;
  // Host events set flags; core access clears, set wins
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      wflag_r <= '0;
      rflag_r <= '0;
    end
    else
    begin
      wflag_r <= (wflag_r & ~((core_re && core_addr < 3'(mailbox_pkg::NUM_DATA))
        ? (6'h01 << core_addr) : 6'h00)) | wr_pulse_r;
      rflag_r <= (rflag_r & ~((core_we && core_addr < 3'(mailbox_pkg::NUM_DATA))
        ? (6'h01 << core_addr) : 6'h00)) | rd_pulse_r;
    end
  // Core read data is registered, one cycle after the request
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst) core_rdata <= mailbox_pkg::WORD_ZERO;
    else if (core_re)
      core_rdata <= (core_addr == mailbox_pkg::ADDR_STAT_LO) ? {10'h000, wflag_r}
        : (core_addr == mailbox_pkg::ADDR_STAT_HI) ? {8'h00, srst_bit_r, 1'b0, rflag_r}
        : data_r[core_addr];

  // --------------------------------------------------------------
  // Soft reset
  // --------------------------------------------------------------
  assign srst_go = (st_r == ST_WR && !wr_done_r && acc_addr_r == mailbox_pkg::ADDR_STAT_HI
    && ps_r.bus[mailbox_pkg::SRST_BIT])
    || (core_we && core_addr == mailbox_pkg::ADDR_STAT_HI
    && core_wdata[mailbox_pkg::SRST_BIT]);
  // Counter runs the pulse; status bit clears when the pulse ends
  always_ff @(posedge mclk or posedge sys_rst)
    if (sys_rst)
    begin
      srst_cnt_r <= 3'h0;
      srst_bit_r <= 1'b0;
    end
    else if (srst_go && srst_cnt_r == 3'h0)
    begin
      srst_cnt_r <= 3'(mailbox_pkg::SRST_CYCLES);
      srst_bit_r <= 1'b1;
    end
    else if (srst_cnt_r != 3'h0)
    begin
      srst_cnt_r <= srst_cnt_r - 3'h1;
      srst_bit_r <= srst_cnt_r != 3'h1;
    end
  assign soft_rst = srst_cnt_r != 3'h0;

  // --------------------------------------------------------------
  // Boot FIFO and interrupts
  // --------------------------------------------------------------
  boot_fifo #(.WIDTH(8), .DEPTH(16)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(ps_r.bus),
    .out_valid(boot_valid),
    .out_ready(boot_ready),
    .out_data(boot_byte)
  );
  irq_prio u_irq (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ext_irq_n(ext_irq_n),
    .irq_control_reg(irq_control_reg),
    .src_pulse({other_irq_pulse[8:2], |(rd_pulse_r & per_register_irq_mask[11:6]),
      |(wr_pulse_r & per_register_irq_mask[5:0]), other_irq_pulse[1:0]}),
    .global_irq_mask(global_irq_mask),
    .force_bits(force_bits),
    .clear_bits(clear_bits),
    .irq_force_clear_we(irq_force_clear_we),
    .ints_enable(ints_enable),
    .ints_disable(ints_disable),
    .irq_ack(irq_ack),
    .soft_rst(soft_rst),
    .irq_valid(irq_valid),
    .irq_vector(irq_vector)
  );

  sequence s_srst_hold;
    soft_rst [*5] ##1 !soft_rst;
  endsequence
  property p_srst_len;
    @(posedge mclk) disable iff (sys_rst) $rose(soft_rst) |-> s_srst_hold;
  endproperty
  a_srst_len: assert property (p_srst_len) else $error("soft reset length");
  property p_upper_zero;
    @(posedge mclk) disable iff (sys_rst)
      wr_pulse_r[0] |-> data_r[0][15:8] == 8'h00 ##1 wflag_r[0];
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper byte not zero");
  property p_rflag;
    @(posedge mclk) disable iff (sys_rst) rd_pulse_r[1] |=> rflag_r[1];
  endproperty
  a_rflag: assert property (p_rflag) else $error("read flag missed");
  property p_ack_sel;
    @(posedge mclk) disable iff (sys_rst) host_ack_out |-> sel || $past(sel);
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("ack without select");
  sequence s_read_end;
    st_r == ST_RD ##1 st_r == ST_IDLE;
  endsequence
  property p_rd_evt;
    @(posedge mclk) disable iff (sys_rst)
      s_read_end |-> (acc_addr_r >= 3'h6 || $past(acc_addr_r) >= 3'h6 || |rd_pulse_r);
  endproperty
  a_rd_evt: assert property (p_rd_evt) else $error("read event missing");
  property p_no_boot_write;
    @(posedge mclk) disable iff (sys_rst) boot_mode |-> wr_pulse_r == 6'h00;
  endproperty
  a_no_boot_write: assert property (p_no_boot_write) else $error("boot wrote mailbox");
endmodule // host_mailbox_port

// ### bench/host_model.sv
/*
  Host processor model: byte writes and reads on the mailbox port pins.
  Assumes the bench resolves the shared byte bus from the port's drive enable.
*/
module host_model (
  input wire logic mclk,
  input wire logic strobe_style_strap,
  input wire logic bus_mux_strap,
  input wire logic host_ack_out,
  input wire logic [7:0] host_byte_bus_in,
  output logic host_sel_n,
  output logic host_read_or_dir,
  output logic host_write_or_strobe,
  output logic host_addr2_or_latch,
  output logic [1:0] host_addr_low,
  output logic [7:0] host_drv
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins; a released bus flips so stale data never passes
  initial
  begin
    host_sel_n = 1'b1;
    host_read_or_dir = 1'b1;
    host_write_or_strobe = 1'b1;
    host_addr2_or_latch = 1'b0;
    host_addr_low = 2'h0;
    host_drv = 8'h5A;
  end
  // One access, held until acknowledge is seen or lim negative edges pass
  task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] wd,
                        input int lim, output logic [7:0] rd, output logic ok);
    int n;
    n = 0;
    @(posedge mclk);
    if (bus_mux_strap)
    begin
      host_drv <= {5'h00, a};
      host_addr2_or_latch <= 1'b1;
      repeat (4) @(posedge mclk);
      host_addr2_or_latch <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    else
    begin
      host_addr2_or_latch <= a[2];
      host_addr_low <= a[1:0];
    end
    host_sel_n <= 1'b0;
    host_drv <= wr ? wd : ~host_drv;
    if (strobe_style_strap)
    begin
      host_read_or_dir <= ~wr;
      host_write_or_strobe <= 1'b0;
    end
    else if (wr)
      host_write_or_strobe <= 1'b0;
    else
      host_read_or_dir <= 1'b0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (host_ack_out !== 1'b1 && n < lim);
    ok = host_ack_out;
    // Read byte stands together with acknowledge
    rd = host_byte_bus_in;
    @(posedge mclk);
    host_sel_n <= 1'b1;
    host_read_or_dir <= 1'b1;
    host_write_or_strobe <= 1'b1;
    host_drv <= ~host_drv;
    repeat (8) @(posedge mclk);
  endtask
endmodule // host_model

// ### bench/testbench.sv
/*
  Self-checking bench of the host mailbox port.
  Assumes the host model file is compiled first.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic mclk = 1'b0, sys_rst = 1'b1;
  logic host_sel_n, host_read_or_dir, host_write_or_strobe, host_addr2_or_latch;
  logic [1:0] host_addr_low;
  logic [7:0] host_drv, host_byte_bus_in, host_byte_bus_out, boot_byte;
  logic host_byte_bus_oe, host_ack_out, boot_valid, soft_rst, irq_valid;
  logic strobe_style_strap = 1'b0, bus_mux_strap = 1'b0, boot_source_strap = 1'b0;
  logic memory_map_pin = 1'b1, core_we = 1'b0, core_re = 1'b0, boot_ready = 1'b1;
  logic irq_force_clear_we = 1'b0, ints_enable = 1'b0, ints_disable = 1'b0, irq_ack = 1'b0;
  logic [2:0] core_addr = 3'h0, ext_irq_n = 3'h7, irq_control_reg = 3'h0;
  logic [15:0] core_wdata = 16'h0000, core_rdata, irq_vector, d;
  logic [11:0] per_register_irq_mask = 12'h000;
  logic [8:0] other_irq_pulse = 9'h000;
  logic [9:0] global_irq_mask = 10'h3FF;
  logic [10:0] force_bits = 11'h000, clear_bits = 11'h000;
  logic [7:0] got_q[$];
  int error_cnt = 0, compares = 0, cycles = 0, srst_len = 0;
  // Shared byte bus: the port wins while it drives
  assign host_byte_bus_in = host_byte_bus_oe ? host_byte_bus_out : host_drv;
  always #5 mclk = ~mclk;
  host_mailbox_port DUT (.mclk, .sys_rst, .host_sel_n, .host_read_or_dir,
    .host_write_or_strobe, .host_addr2_or_latch, .host_addr_low, .host_byte_bus_in,
    .host_byte_bus_out, .host_byte_bus_oe, .host_ack_out, .strobe_style_strap,
    .bus_mux_strap, .boot_source_strap, .memory_map_pin, .core_addr, .core_we, .core_re,
    .core_wdata, .core_rdata, .per_register_irq_mask, .boot_valid, .boot_ready, .boot_byte,
    .soft_rst, .ext_irq_n, .irq_control_reg, .other_irq_pulse, .global_irq_mask,
    .force_bits, .clear_bits, .irq_force_clear_we, .ints_enable, .ints_disable, .irq_ack,
    .irq_valid, .irq_vector);
  host_model host (.mclk, .strobe_style_strap, .bus_mux_strap, .host_ack_out,
    .host_byte_bus_in, .host_sel_n, .host_read_or_dir, .host_write_or_strobe,
    .host_addr2_or_latch, .host_addr_low, .host_drv);
  // Cycle ceiling, soft reset width, boot stream capture
  always @(posedge mclk)
  begin
    cycles++;
    if (soft_rst === 1'b1)
      srst_len++;
    if (boot_valid === 1'b1 && boot_ready === 1'b1)
      got_q.push_back(boot_byte);
    if (cycles == 20000)
    begin
      error_cnt++;
      test_done();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic core_rd(input logic [2:0] a);
    @(posedge mclk);
    core_addr <= a;
    core_re <= 1'b1;
    @(posedge mclk);
    core_re <= 1'b0;
    @(negedge mclk);
    d = core_rdata;
    @(posedge mclk);
  endtask
  task automatic core_wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge mclk);
    core_addr <= a;
    core_wdata <= v;
    core_we <= 1'b1;
    @(posedge mclk);
    core_we <= 1'b0;
  endtask
  task automatic hw(input logic [2:0] a, input logic [7:0] v);
    logic [7:0] r;
    logic ok;
    host.access(1'b1, a, v, 40, r, ok);
    check(16'(ok), 16'h0001);
  endtask
  task automatic hr(input logic [2:0] a, input logic [7:0] v);
    logic [7:0] r;
    logic ok;
    host.access(1'b0, a, 8'h00, 40, r, ok);
    check({ok, 7'h00, r}, {8'h80, v});
  endtask
  // Wait for a request, compare its vector, then acknowledge it
  task automatic irq_seen(input logic [15:0] v);
    int n;
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (irq_valid !== 1'b1 && n < 40);
    check((irq_valid === 1'b1) ? irq_vector : 16'hFFFF, v);
    @(posedge mclk);
    irq_ack <= 1'b1;
    @(posedge mclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic no_irq();
    repeat (20) @(negedge mclk);
    check(16'(irq_valid), 16'h0000);
    @(posedge mclk);
  endtask
  task automatic pulse_src(input logic [8:0] p);
    @(posedge mclk);
    other_irq_pulse <= p;
    @(posedge mclk);
    other_irq_pulse <= 9'h000;
  endtask
  task automatic do_reset(input logic mm, input logic bs, input logic st, input logic mx);
    @(posedge mclk);
    memory_map_pin <= mm;
    boot_source_strap <= bs;
    strobe_style_strap <= st;
    bus_mux_strap <= mx;
    sys_rst <= 1'b1;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic test_done();
    $display("compares %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Host bytes land zero-extended; written flags set, core reads clear them
  task automatic t_mailbox();
    check({11'h000, host_ack_out, host_byte_bus_oe, soft_rst, irq_valid, boot_valid},
      16'h0000);
    for (int i = 0; i < 6; i++)
      core_wr(3'(i), 16'hFFFF);
    for (int i = 0; i < 6; i++)
      hw(3'(i), 8'hA0 + 8'(i));
    hw(3'h6, 8'hFF);
    core_rd(3'h6);
    check({10'h000, d[5:0]}, 16'h003F);
    for (int i = 0; i < 6; i++)
    begin
      core_rd(3'(i));
      check(d, {8'h00, 8'hA0 + 8'(i)});
    end
    core_rd(3'h6);
    check({10'h000, d[5:0]}, 16'h0000);
  endtask
  // Host read of a core word: read flag and masked read request
  task automatic t_read();
    core_wr(3'h1, 16'h5A3C);
    hr(3'h1, 8'h3C);
    core_rd(3'h7);
    check({10'h000, d[5:0]}, 16'h0002);
    per_register_irq_mask <= 12'h080;
    hr(3'h1, 8'h3C);
    irq_seen(16'h000C);
  endtask
  // Write request needs both the per-register and the class enable
  task automatic t_write_irq();
    per_register_irq_mask <= 12'h010;
    hw(3'h4, 8'h11);
    irq_seen(16'h0008);
    global_irq_mask <= 10'h3FD;
    hw(3'h4, 8'h12);
    no_irq();
    global_irq_mask <= 10'h3FF;
    per_register_irq_mask <= 12'h020;
    // The request latched while masked fires once its class is enabled
    irq_seen(16'h0008);
    hw(3'h4, 8'h13);
    no_irq();
  endtask
  // Priority, masking, pin sense, global disable, force and clear
  task automatic t_prio();
    pulse_src(9'h101);
    irq_seen(16'h002C);
    irq_seen(16'h0028);
    ext_irq_n <= 3'h6;
    // Pin level needs the synchroniser's latency before it counts
    repeat (5) @(posedge mclk);
    pulse_src(9'h100);
    irq_seen(16'h0004);
    ext_irq_n <= 3'h7;
    repeat (5) @(posedge mclk);
    irq_seen(16'h0028);
    irq_control_reg <= 3'h2;
    ext_irq_n <= 3'h5;
    repeat (3) @(posedge mclk);
    ext_irq_n <= 3'h7;
    irq_seen(16'h0020);
    global_irq_mask <= 10'h1FF;
    pulse_src(9'h100);
    no_irq();
    global_irq_mask <= 10'h3FF;
    ints_disable <= 1'b1;
    @(posedge mclk);
    ints_disable <= 1'b0;
    pulse_src(9'h100);
    no_irq();
    ints_enable <= 1'b1;
    @(posedge mclk);
    ints_enable <= 1'b0;
    irq_seen(16'h0028);
    // Force two sources, then cancel one of them in a second write
    irq_force_clear_we <= 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      force_bits <= (k == 0) ? 11'h028 : 11'h000;
      clear_bits <= (k == 0) ? 11'h000 : 11'h020;
      @(posedge mclk);
    end
    irq_force_clear_we <= 1'b0;
    irq_seen(16'h000C);
    no_irq();
  endtask
  // Soft reset from the host and the core, all four strobe-style and bus-mux strap mixes, then the boot stream
  task automatic t_modes();
    srst_len = 0;
    hw(3'h7, 8'h80);
    repeat (20) @(posedge mclk);
    check(16'(srst_len), 16'h0005);
    srst_len = 0;
    core_wr(3'h7, 16'h0080);
    repeat (20) @(posedge mclk);
    check(16'(srst_len), 16'h0005);
    for (int m = 0; m < 4; m++)
    begin
      do_reset(m != 0, 1'b0, m[0], m[1]);
      hw(3'(m), 8'h50 + 8'(m));
      core_rd(3'(m));
      check(d, 16'h0050 + 16'(m));
      core_wr(3'h5, 16'h00C0 + 16'(m));
      hr(3'h5, 8'hC0 + 8'(m));
    end
    do_reset(1'b0, 1'b1, 1'b0, 1'b0);
    boot_ready <= 1'b0;
    got_q.delete();
    for (int i = 0; i < 16; i++)
      hw(3'(i), 8'h20 + 8'(i));
    fork
      hw(3'h0, 8'h30);
      begin
        repeat (30) @(negedge mclk);
        check(16'(host_ack_out), 16'h0000);
        @(posedge mclk);
        boot_ready <= 1'b1;
      end
    join
    // Let the FIFO drain all seventeen bytes before counting
    repeat (20) @(posedge mclk);
    check(16'(got_q.size()), 16'h0011);
    for (int i = 0; i < got_q.size(); i++)
      check(16'(got_q[i]), (i < 16) ? 16'h0020 + 16'(i) : 16'h0030);
    core_rd(3'h6);
    check({10'h000, d[5:0]}, 16'h0000);
  endtask
  // Main sequence
  initial
  begin
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    t_mailbox();
    t_read();
    t_write_irq();
    t_prio();
    t_modes();
    test_done();
  end
endmodule // testbench
